// File: hw/xfer_irq_cfg.svh
`ifndef XFER_IRQ_CFG_SVH
`define XFER_IRQ_CFG_SVH

// Register byte addresses
`define STATUS_OFS 12'h260
`define CLEAR_OFS 12'h268
`define STATUS_RST 32'h0000_0000

// Condition positions within a unit's byte
`define POS_CREDIT 7
`define POS_RETRY 6
`define POS_FETCH 5
`define POS_TIMEOUT 4
`define POS_BADENC 3
`define POS_XOFF 2
`define POS_ERRRESP 1
`define POS_DONE 0
`define UNIT_BITS 8
`define NUM_UNITS 4

// Bus response codes
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: hw/xfer_irq_pkg.sv
package xfer_irq_pkg;

  // Per-unit event pulses from the transfer unit datapath
  typedef struct packed {
    logic credit_drop;
    logic doorbell_retry;
    logic swap_refused;
    logic fetch_err;
    logic timeout;
    logic err_resp;
    logic payload_err;
    logic done;
  } unit_evt_t;

  // Per-unit send request with encoding check and interrupt enable
  typedef struct packed {
    logic send;
    logic bad_encoding;
    logic irq_req;
  } unit_req_t;

endpackage : xfer_irq_pkg

// File: hw/xfer_unit_irq_status_clear.sv
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/10ps
`include "xfer_irq_cfg.svh"

module xfer_unit_irq_status_clear (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Transfer unit events
  input xfer_irq_pkg::unit_evt_t [3:0] unit_evt,
  input xfer_irq_pkg::unit_req_t [3:0] unit_req,
  input wire logic flow_off,
  output logic [3:0] tx_go,
  output logic [31:0] status_out,
  // AXI4-Lite write
  input wire logic [11:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // AXI4-Lite read
  input wire logic [11:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);

  // Status word, its next value and the set and clear masks
  logic [31:0] status_ff;
  logic [31:0] nxt_status;
  logic [31:0] set_vec;
  logic [31:0] clr_vec;

  // Send path flops
  logic [3:0] tx_go_ff;
  logic [3:0] ireq_ff;

  // Bus channel state
  logic aw_got_ff;
  logic w_got_ff;
  logic [11:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic wr_fire;
  logic [31:0] strb_mask;

  // Per-unit condition detection, same bit order in every byte
  genvar u;
  generate
    for (u = 0; u < `NUM_UNITS; u++) begin : g_unit
      // Refused and held sends of this unit
      logic bad;
      logic held;
      assign bad = unit_req[u].send & unit_req[u].bad_encoding;
      assign held = unit_req[u].send & ~unit_req[u].bad_encoding & flow_off;
      assign set_vec[u*`UNIT_BITS+`POS_CREDIT] = unit_evt[u].credit_drop;
      assign set_vec[u*`UNIT_BITS+`POS_RETRY] =
          unit_evt[u].doorbell_retry | unit_evt[u].swap_refused;
      assign set_vec[u*`UNIT_BITS+`POS_FETCH] = unit_evt[u].fetch_err;
      assign set_vec[u*`UNIT_BITS+`POS_TIMEOUT] = unit_evt[u].timeout;
      assign set_vec[u*`UNIT_BITS+`POS_BADENC] = bad;
      assign set_vec[u*`UNIT_BITS+`POS_XOFF] = held;
      assign set_vec[u*`UNIT_BITS+`POS_ERRRESP] =
          unit_evt[u].err_resp | unit_evt[u].payload_err;
      assign set_vec[u*`UNIT_BITS+`POS_DONE] = unit_evt[u].done & ireq_ff[u];

      // Send goes out only when encoding is good and link is not off
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          tx_go_ff[u] <= 1'b0;
        end else begin
          tx_go_ff[u] <= unit_req[u].send & ~bad & ~held;
        end
      end

      // Interrupt enable captured with each accepted request
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          ireq_ff[u] <= 1'b0;
        end else if (unit_req[u].send & ~bad & ~held) begin
          ireq_ff[u] <= unit_req[u].irq_req;
        end
      end
    end
  endgenerate

  // Byte lanes of the write data that software really drove
  assign strb_mask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
  assign wr_fire = aw_got_ff & w_got_ff & ~bvalid_ff;
  assign clr_vec = (wr_fire && awaddr_ff == `CLEAR_OFS) ? (wdata_ff & strb_mask) : 32'h0;

  // Sticky status, detection wins over clear
  always_comb begin
    nxt_status = (status_ff & ~clr_vec) | set_vec;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      status_ff <= `STATUS_RST;
    end else begin
      status_ff <= nxt_status;
    end
  end

  // Write address and data taken independently
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= 12'h000;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
    end else begin
      if (s_awvalid && awready_ff) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_awaddr;
      end else if (s_bvalid && s_bready) begin
        aw_got_ff <= 1'b0;
      end
      if (s_wvalid && wready_ff) begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_wdata;
        wstrb_ff <= s_wstrb;
      end else if (s_bvalid && s_bready) begin
        w_got_ff <= 1'b0;
      end
      awready_ff <= ~aw_got_ff & ~(s_awvalid & awready_ff) & ~bvalid_ff;
      wready_ff <= ~w_got_ff & ~(s_wvalid & wready_ff) & ~bvalid_ff;
    end
  end

  // Write response after both halves arrive
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= `RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= (awaddr_ff == `CLEAR_OFS) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bvalid_ff && s_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Read channel, clear register reads as zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= `RESP_OKAY;
    end else if (s_arvalid && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      if (s_araddr == `STATUS_OFS) begin
        rdata_ff <= status_ff;
        rresp_ff <= `RESP_OKAY;
      end else if (s_araddr == `CLEAR_OFS) begin
        rdata_ff <= 32'h0000_0000;
        rresp_ff <= `RESP_OKAY;
      end else begin
        rdata_ff <= 32'h0000_0000;
        rresp_ff <= `RESP_SLVERR;
      end
    end else if (rvalid_ff && s_rready) begin
      rvalid_ff <= 1'b0;
    end else if (!rvalid_ff) begin
      arready_ff <= 1'b1;
    end
  end

  // Outputs straight from flops
  assign tx_go = tx_go_ff;
  assign status_out = status_ff;
  assign s_awready = awready_ff;
  assign s_wready = wready_ff;
  assign s_bvalid = bvalid_ff;
  assign s_bresp = bresp_ff;
  assign s_arready = arready_ff;
  assign s_rvalid = rvalid_ff;
  assign s_rdata = rdata_ff;
  assign s_rresp = rresp_ff;

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // Unit one condition bits
  credit_sets_bit_a:
    assert property (unit_evt[0].credit_drop |=> status_ff[7])
    else $error("credit drop did not set bit 7");
  retry_sets_bit_a:
    assert property (unit_evt[0].doorbell_retry || unit_evt[0].swap_refused
                     |=> status_ff[6])
    else $error("retry or refused swap did not set bit 6");
  fetch_sets_bit_a:
    assert property (unit_evt[0].fetch_err |=> status_ff[5])
    else $error("fetch error did not set bit 5");
  timeout_sets_bit_a:
    assert property (unit_evt[0].timeout |=> status_ff[4])
    else $error("timeout did not set bit 4");
  bad_enc_blocks_a:
    assert property (unit_req[0].send && unit_req[0].bad_encoding |=> status_ff[3] && !tx_go[0])
    else $error("bad encoding was sent or not flagged");
  xoff_holds_a:
    assert property (unit_req[0].send && !unit_req[0].bad_encoding && flow_off
                     |=> status_ff[2] && !tx_go[0])
    else $error("transmit-off send not held");
  err_resp_bit_a:
    assert property (unit_evt[0].err_resp || unit_evt[0].payload_err
                     |=> status_ff[1])
    else $error("error reply did not set bit 1");
  done_sets_bit_a:
    assert property (unit_evt[0].done && ireq_ff[0] |=> status_ff[0])
    else $error("enabled completion did not set bit 0");
  done_gated_a:
    assert property (unit_evt[0].done && !status_ff[0] && !ireq_ff[0]
                     |=> !status_ff[0])
    else $error("completion flagged without enable");

  // Other units in the same order
  unit_four_map_a:
    assert property (unit_evt[3].timeout |=> status_ff[28])
    else $error("unit four timeout not in bit 28");
  unit_two_map_a:
    assert property (unit_evt[1].credit_drop |=> status_ff[15])
    else $error("unit two credit drop not in bit 15");
  fetch_unit_two_a:
    assert property (unit_evt[1].fetch_err |=> status_ff[13])
    else $error("unit two fetch error not in bit 13");
  unit_three_map_a:
    assert property (unit_evt[2].err_resp |=> status_ff[17])
    else $error("unit three error reply not in bit 17");
  unit_two_xoff_a:
    assert property (unit_req[1].send && !unit_req[1].bad_encoding && flow_off
                     |=> status_ff[10] && !tx_go[1])
    else $error("unit two transmit-off not in bit 10");
  unit_three_done_a:
    assert property (unit_evt[2].done && ireq_ff[2] |=> status_ff[16])
    else $error("unit three completion not in bit 16");

  // Send acceptance and enable capture
  good_send_goes_a:
    assert property (unit_req[0].send && !unit_req[0].bad_encoding && !flow_off
                     |=> tx_go[0])
    else $error("good send did not go out");
  idle_no_go_a:
    assert property (!unit_req[0].send |=> !tx_go[0])
    else $error("send pulse without a request");
  irq_capture_a:
    assert property (unit_req[0].send && !unit_req[0].bad_encoding && !flow_off
                     |=> ireq_ff[0] == $past(unit_req[0].irq_req))
    else $error("interrupt enable not taken with the send");
  irq_kept_a:
    assert property (unit_req[0].send && (unit_req[0].bad_encoding || flow_off)
                     |=> ireq_ff[0] == $past(ireq_ff[0]))
    else $error("refused send changed the interrupt enable");

  // Clear by written ones, hold otherwise
  clear_one_a:
    assert property (clr_vec[4] && !set_vec[4] |=> !status_ff[4])
    else $error("written one did not clear bit 4");
  set_beats_clear_a:
    assert property (clr_vec[13] && set_vec[13] |=> status_ff[13])
    else $error("same-cycle detection lost to clear");
  sticky_hold_a:
    assert property (status_ff[13] && !clr_vec[13] |=> status_ff[13])
    else $error("status bit dropped without clear");
  clear_zero_a:
    assert property (status_ff[23] && wr_fire && !wdata_ff[23] |=> status_ff[23])
    else $error("written zero cleared bit 23");
  clear_unit_four_a:
    assert property (clr_vec[31] && !set_vec[31] |=> !status_ff[31])
    else $error("written one did not clear bit 31");
  unit_two_clear_a:
    assert property (clr_vec[9] && !set_vec[9] |=> !status_ff[9])
    else $error("written one did not clear bit 9");
  write_resp_a:
    assert property (wr_fire |=> s_bvalid)
    else $error("no response after a write");

  // Main scenarios reached
  write_clear_c: cover property (wr_fire && clr_vec != 32'h0);
  status_read_c: cover property (s_rvalid && s_rready && s_rdata != 32'h0);
  race_c: cover property (clr_vec[13] && set_vec[13]);
  done_enabled_c: cover property (unit_evt[0].done && ireq_ff[0]);
  held_send_c: cover property (unit_req[0].send && flow_off);

endmodule : xfer_unit_irq_status_clear

// File: bench/tb_xfer_unit_irq_status_clear.sv
`timescale 1ns/10ps
`include "xfer_irq_cfg.svh"

module tb_xfer_unit_irq_status_clear;
  // Stimulus and observed signals
  logic mclk = 1'b0;
  logic rst = 1'b1;
  xfer_irq_pkg::unit_evt_t [3:0] unit_evt = '0;
  xfer_irq_pkg::unit_req_t [3:0] unit_req = '0;
  logic flow_off = 1'b0;
  logic [3:0] tx_go;
  logic [31:0] status_out, s_rdata, rd;
  logic [31:0] s_wdata = '0;
  logic [11:0] s_awaddr = '0, s_araddr = '0;
  logic [3:0] s_wstrb = 4'hf;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
  logic s_arvalid = 1'b0, s_rready = 1'b0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, s_rresp, resp;
  int fails = 0;
  int check_count = 0;

  xfer_unit_irq_status_clear dut_u (
    .mclk, .rst, .unit_evt, .unit_req, .flow_off, .tx_go, .status_out,
    .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready,
    .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
    .s_rdata, .s_rresp, .s_rvalid, .s_rready
  );

  // Free-running 125 MHz clock
  always #4 mclk = ~mclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim

  // Bus write, address and data offered together
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
    end while (s_bvalid !== 1'b1);
    resp = s_bresp;
    s_bready <= 1'b0;
  endtask : wr

  task automatic rdw(input logic [11:0] a);
    @(posedge mclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_arready) s_arvalid <= 1'b0;
    end while (s_rvalid !== 1'b1);
    rd = s_rdata;
    resp = s_rresp;
    s_rready <= 1'b0;
  endtask : rdw

  task automatic settle();
    repeat (2) @(posedge mclk);
    #1;
  endtask : settle

  task automatic pulse(input int u, input int b);
    @(posedge mclk);
    unit_evt[u][b] <= 1'b1;
    @(posedge mclk);
    unit_evt[u][b] <= 1'b0;
    settle();
  endtask : pulse

  task automatic clr();
    wr(`CLEAR_OFS, 32'hffff_ffff);
    settle();
    chk(status_out, 32'h0, "clear all");
  endtask : clr

  task automatic send(input int u, input logic bad, input logic irq, input logic xoff,
                      input logic go);
    @(posedge mclk);
    unit_req[u] <= '{send: 1'b1, bad_encoding: bad, irq_req: irq};
    flow_off <= xoff;
    @(posedge mclk);
    unit_req[u] <= '0;
    flow_off <= 1'b0;
    #1;
    chk({28'h0, tx_go}, go ? 32'h1 << u : 32'h0, "tx_go");
    settle();
  endtask : send

  // Every event field but done of every unit lands on its status bit
  task automatic evt_map();
    int map [8] = '{0, 1, 1, 4, 5, 6, 6, 7};
    logic [31:0] e;
    for (int u = 0; u < 4; u++) begin
      for (int b = 1; b < 8; b++) begin
        e = 32'h1 << (8 * u + map[b]);
        pulse(u, b);
        chk(status_out, e, "evt");
        rdw(`STATUS_OFS);
        chk(rd, e, "rd");
        clr();
      end
    end
  endtask : evt_map

  // Accepted, refused and held sends, completion gating
  task automatic send_paths();
    for (int u = 0; u < 4; u++) begin
      send(u, 1'b0, 1'b1, 1'b0, 1'b1);
      pulse(u, 0);
      chk(status_out, 32'h1 << (8 * u), "done");
      clr();
      send(u, 1'b1, 1'b1, 1'b0, 1'b0);
      chk(status_out, 32'h8 << (8 * u), "bad enc");
      clr();
      send(u, 1'b0, 1'b0, 1'b1, 1'b0);
      chk(status_out, 32'h4 << (8 * u), "xoff");
      clr();
      send(u, 1'b0, 1'b0, 1'b0, 1'b1);
      pulse(u, 0);
      chk(status_out, 32'h0, "done masked");
    end
  endtask : send_paths

  // Partial clear, then a detection held across a full clear
  task automatic clear_mix();
    @(posedge mclk);
    unit_evt <= 32'h8888_8888;
    @(posedge mclk);
    unit_evt <= '0;
    settle();
    chk(status_out, 32'h9090_9090, "multi");
    wr(`CLEAR_OFS, 32'h8010_0010);
    settle();
    chk(status_out, 32'h1080_9080, "partial");
    // Fetch error pulse lands on the very edge that applies the clear
    fork
      wr(`CLEAR_OFS, 32'hffff_ffff);
      begin
        repeat (2) @(posedge mclk);
        unit_evt[1].fetch_err <= 1'b1;
        @(posedge mclk);
        unit_evt[1].fetch_err <= 1'b0;
      end
    join
    settle();
    chk(status_out, 32'h0000_2000, "set wins");
    clr();
  endtask : clear_mix

  // Reset in mid-run wipes the status word
  task automatic mid_reset();
    pulse(3, 7);
    chk(status_out, 32'h8000_0000, "pre reset");
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    settle();
    chk(status_out, `STATUS_RST, "mid reset");
    rdw(`STATUS_OFS);
    chk(rd, `STATUS_RST, "mid reset rd");
  endtask : mid_reset

  // Read-only, write-only, masked lanes and unmapped places
  task automatic bus_map();
    pulse(2, 3);
    wr(`STATUS_OFS, 32'hffff_ffff);
    chk({30'h0, resp}, {30'h0, `RESP_SLVERR}, "ro wr");
    settle();
    chk(status_out, 32'h0010_0000, "ro keep");
    @(posedge mclk);
    s_wstrb <= 4'hb;
    wr(`CLEAR_OFS, 32'hffff_ffff);
    @(posedge mclk);
    s_wstrb <= 4'hf;
    settle();
    chk(status_out, 32'h0010_0000, "lane off");
    rdw(`CLEAR_OFS);
    chk(rd, 32'h0, "wo rd");
    chk({30'h0, resp}, {30'h0, `RESP_OKAY}, "wo resp");
    rdw(12'h100);
    chk({30'h0, resp}, {30'h0, `RESP_SLVERR}, "unmapped");
    chk(rd, 32'h0, "unmapped rd");
    clr();
  endtask : bus_map

  // Main sequence
  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    settle();
    chk(status_out, `STATUS_RST, "reset");
    rdw(`STATUS_OFS);
    chk(rd, `STATUS_RST, "reset rd");
    evt_map();
    send_paths();
    clear_mix();
    mid_reset();
    bus_map();
    end_sim();
  end

  // Watchdog against a hung handshake
  initial begin
    #200000;
    fails++;
    end_sim();
  end
endmodule : tb_xfer_unit_irq_status_clear
